// >>> verilog/hwm_defines.vh
// Register map, field positions, reset values and timing for the monitor bank
`ifndef HWM_DEFINES_VH
`define HWM_DEFINES_VH

// Register offsets
`define HWM_ADDR_CONTROL    8'h40
`define HWM_ADDR_STATUS1    8'h41
`define HWM_ADDR_STATUS2    8'h42
`define HWM_ADDR_MASK1      8'h43
`define HWM_ADDR_MASK2      8'h44
`define HWM_ADDR_CASE_CLR   8'h46

// Reset values
`define HWM_RST_CONTROL     8'h08
`define HWM_RST_STATUS      8'h00
`define HWM_RST_MASK        8'h00
`define HWM_RST_CASE_CLR    8'h00

// Control register fields
`define HWM_CTL_RUN         0
`define HWM_CTL_INT_EN      1
`define HWM_CTL_RSV2        2
`define HWM_CTL_SUSPEND     3
`define HWM_CTL_RESET_REQ   4
`define HWM_CTL_RSV5        5
`define HWM_CTL_CASE_CLR    6
`define HWM_CTL_RESTORE     7

// Intrusion-clear register field
`define HWM_CCLR_REQ        7

// Status one fields
`define HWM_ST1_RAIL_2V5    0
`define HWM_ST1_CORE_ONE    1
`define HWM_ST1_RAIL_3V3    2
`define HWM_ST1_RAIL_5V     3
`define HWM_ST1_TEMP_HIGH   4
`define HWM_ST1_TACH_ONE    6
`define HWM_ST1_TACH_TWO    7
`define HWM_ST1_IMPL        8'hdf

// Status two fields
`define HWM_ST2_RAIL_12V    0
`define HWM_ST2_CORE_TWO    1
`define HWM_ST2_CASE_OPEN   4
`define HWM_ST2_TEMP_LOW    7
`define HWM_ST2_IMPL        8'h93
`define HWM_MASK2_ALARM     8'h13
`define HWM_MASK2_RESET_EN  7

// Pulse timing
`define HWM_PULSE_TIME_MS   20
`define HWM_CLK_KHZ         10000
`define HWM_PULSE_CYCLES    (`HWM_PULSE_TIME_MS * `HWM_CLK_KHZ)
`define HWM_PULSE_CNT_W     18

`endif

// >>> verilog/hwm_pulse_timer.v
// Active-low pulse generator of fixed length, cut short by abort
`timescale 1ns/10ps
module hwm_pulse_timer #(
  parameter CNT_W  = 18,
  parameter CYCLES = 200000
) (
  input  wire             clk,
  input  wire             reset_n,
  input  wire             abort,
  input  wire             start,
  output wire             busy,
  output reg              pulse_n_q,
  output wire             done
);

  localparam [31:0]      LAST_FULL = CYCLES - 1;
  localparam [CNT_W-1:0] LAST      = LAST_FULL[CNT_W-1:0];

  reg [CNT_W-1:0] cnt_q;
  reg             busy_q;

  assign busy = busy_q;
  assign done = busy_q && (cnt_q == LAST) && !abort;

  always @(posedge clk) begin
    if (!reset_n || abort) begin
      cnt_q     <= {CNT_W{1'b0}};
      busy_q    <= 1'b0;
      pulse_n_q <= 1'b1;
    end else if (!busy_q) begin
      cnt_q <= {CNT_W{1'b0}};
      if (start) begin
        busy_q    <= 1'b1;
        pulse_n_q <= 1'b0;
      end
    end else if (cnt_q == LAST) begin
      busy_q    <= 1'b0;
      pulse_n_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

endmodule

// >>> verilog/hwm_regs.v
// Monitor control, alarm status and mask registers with pin pulse logic
`timescale 1ns/10ps
`include "hwm_defines.vh"
module hwm_regs #(
  parameter CNT_W        = `HWM_PULSE_CNT_W,
  parameter PULSE_CYCLES = `HWM_PULSE_CYCLES
) (
  input  wire       CLK,
  input  wire       RESET_N,
  input  wire [7:0] REG_ADDR,
  input  wire       REG_WR,
  input  wire [7:0] REG_WDATA,
  input  wire       REG_RD,
  output reg  [7:0] REG_RDATA,
  input  wire       EXTENDED_MODE,
  input  wire       RAIL_2V5_INPUT_ERR,
  input  wire       CORE_SUPPLY_ONE_ERR,
  input  wire       RAIL_3V3_INPUT_ERR,
  input  wire       RAIL_5V_INPUT_ERR,
  input  wire       RAIL_12V_INPUT_ERR,
  input  wire       CORE_SUPPLY_TWO_ERR,
  input  wire       TEMP_HIGH_ERR,
  input  wire       TEMP_BELOW_FLOOR_ERR,
  input  wire       TACH_ONE_ERR,
  input  wire       TACH_TWO_ERR,
  input  wire       CASE_OPEN_INPUT_I,
  output wire       CASE_OPEN_INPUT_O,
  output wire       CASE_OPEN_INPUT_OE,
  output wire       RESET_OUT_N,
  output reg        ALARM_INT_N,
  output reg        MONITOR_RUN,
  output reg        DEFAULTS_RESTORE
);

  // Status update: hardware set wins over the read clear
  function [7:0] status_next;
    input [7:0] old;
    input [7:0] set;
    input       clr;
    input [7:0] impl;
    begin
      status_next = (clr ? (set & impl) : ((old | set) & impl));
    end
  endfunction

  // Strobe qualified by one register address
  function addr_hit;
    input       strobe;
    input [7:0] addr;
    input [7:0] target;
    begin
      addr_hit = strobe && (addr == target);
    end
  endfunction

  reg  [7:0] control_q;
  reg  [7:0] control_d;
  reg  [7:0] status1_q;
  reg  [7:0] status2_q;
  reg  [7:0] mask1_q;
  reg  [7:0] mask2_q;
  reg  [6:0] case_clr_rsv_q;
  reg        case_clr_req_q;
  reg        case_clr_req_d;
  reg        case_s1_q;
  reg        case_s2_q;
  reg        case_s3_q;
  reg        case_level_q;
  reg  [7:0] rdata_d;
  reg  [7:0] st1_set;
  reg  [7:0] st2_set;

  wire       wr_ctl;
  wire       wr_cclr;
  wire       restore;
  wire       reset_busy;
  wire       reset_done;
  wire       reset_start;
  wire       case_busy;
  wire       case_done;
  wire       case_start;
  wire       reset_pulse_n;
  wire       case_pulse_n;
  wire       running;
  wire       alarm_any;
  wire       rd_st1;
  wire       rd_st2;
  wire       wr_mask1;
  wire       wr_mask2;
  wire       alarm_cond;
  wire       case_seen;
  wire [7:0] st1_alarm;
  wire [7:0] st2_alarm;

  assign wr_ctl   = addr_hit(REG_WR, REG_ADDR, `HWM_ADDR_CONTROL);
  assign wr_cclr  = addr_hit(REG_WR, REG_ADDR, `HWM_ADDR_CASE_CLR);
  assign wr_mask1 = addr_hit(REG_WR, REG_ADDR, `HWM_ADDR_MASK1);
  assign wr_mask2 = addr_hit(REG_WR, REG_ADDR, `HWM_ADDR_MASK2);
  assign rd_st1   = addr_hit(REG_RD, REG_ADDR, `HWM_ADDR_STATUS1);
  assign rd_st2   = addr_hit(REG_RD, REG_ADDR, `HWM_ADDR_STATUS2);

  // Restore request never stored, so the bit reads zero
  assign restore = wr_ctl && REG_WDATA[`HWM_CTL_RESTORE];

  // Reset pulse only with the enable in mask two
  assign reset_start = wr_ctl && !restore
                       && REG_WDATA[`HWM_CTL_RESET_REQ]
                       && mask2_q[`HWM_MASK2_RESET_EN]
                       && !reset_busy;

  // Either register can request the intrusion-clear pulse
  assign case_start = !restore && !case_busy
                      && ((wr_ctl && REG_WDATA[`HWM_CTL_CASE_CLR])
                      || (wr_cclr && REG_WDATA[`HWM_CCLR_REQ]));

  // Monitoring runs with run set and suspend clear
  assign running = control_q[`HWM_CTL_RUN]
                   && !control_q[`HWM_CTL_SUSPEND];

  hwm_pulse_timer #(
    .CNT_W  (CNT_W),
    .CYCLES (PULSE_CYCLES)
  ) u_reset_pulse (
    .clk       (CLK),
    .reset_n   (RESET_N),
    .abort     (restore),
    .start     (reset_start),
    .busy      (reset_busy),
    .pulse_n_q (reset_pulse_n),
    .done      (reset_done)
  );

  hwm_pulse_timer #(
    .CNT_W  (CNT_W),
    .CYCLES (PULSE_CYCLES)
  ) u_case_pulse (
    .clk       (CLK),
    .reset_n   (RESET_N),
    .abort     (restore),
    .start     (case_start),
    .busy      (case_busy),
    .pulse_n_q (case_pulse_n),
    .done      (case_done)
  );

  assign RESET_OUT_N        = reset_pulse_n;
  assign CASE_OPEN_INPUT_O  = 1'b0;
  assign CASE_OPEN_INPUT_OE = !case_pulse_n;

  // Control register next value
  always @* begin
    control_d = control_q;
    if (wr_ctl) begin
      control_d[`HWM_CTL_RUN]     = REG_WDATA[`HWM_CTL_RUN];
      control_d[`HWM_CTL_INT_EN]  = REG_WDATA[`HWM_CTL_INT_EN];
      control_d[`HWM_CTL_RSV2]    = REG_WDATA[`HWM_CTL_RSV2];
      control_d[`HWM_CTL_SUSPEND] = REG_WDATA[`HWM_CTL_SUSPEND];
      control_d[`HWM_CTL_RSV5]    = REG_WDATA[`HWM_CTL_RSV5];
    end
    if (reset_start) begin
      control_d[`HWM_CTL_RESET_REQ] = 1'b1;
    end else if (reset_done) begin
      control_d[`HWM_CTL_RESET_REQ] = 1'b0;
    end
    control_d[`HWM_CTL_CASE_CLR] = 1'b0;
    control_d[`HWM_CTL_RESTORE]  = 1'b0;
  end

  always @* begin
    case_clr_req_d = case_clr_req_q;
    if (case_start) begin
      case_clr_req_d = 1'b1;
    end else if (case_done) begin
      case_clr_req_d = 1'b0;
    end
  end

  // Intrusion pin sync, ignored while this end drives it low
  always @(posedge CLK) begin
    if (!RESET_N) begin
      case_s1_q    <= 1'b0;
      case_s2_q    <= 1'b0;
      case_s3_q    <= 1'b0;
      case_level_q <= 1'b0;
    end else begin
      case_s1_q <= CASE_OPEN_INPUT_I;
      case_s2_q <= case_s1_q;
      case_s3_q <= case_s2_q;
      if (case_s2_q == case_s3_q) begin
        case_level_q <= case_s3_q;
      end
    end
  end

  // Pin level counts only while this end leaves it free
  assign case_seen = case_level_q && case_pulse_n;

  // Status set terms from the limit checkers and the intrusion pin
  always @* begin
    st1_set = 8'h00;
    st2_set = 8'h00;
    if (running) begin
      st1_set[`HWM_ST1_RAIL_2V5]  = RAIL_2V5_INPUT_ERR;
      st1_set[`HWM_ST1_CORE_ONE]  = CORE_SUPPLY_ONE_ERR;
      st1_set[`HWM_ST1_RAIL_3V3]  = RAIL_3V3_INPUT_ERR;
      st1_set[`HWM_ST1_RAIL_5V]   = RAIL_5V_INPUT_ERR;
      st1_set[`HWM_ST1_TEMP_HIGH] = TEMP_HIGH_ERR;
      st1_set[`HWM_ST1_TACH_ONE]  = TACH_ONE_ERR;
      st1_set[`HWM_ST1_TACH_TWO]  = TACH_TWO_ERR;
      st2_set[`HWM_ST2_RAIL_12V]  = RAIL_12V_INPUT_ERR;
      st2_set[`HWM_ST2_CORE_TWO]  = CORE_SUPPLY_TWO_ERR;
      st2_set[`HWM_ST2_TEMP_LOW]  = TEMP_BELOW_FLOOR_ERR
                                    && EXTENDED_MODE;
    end
    st2_set[`HWM_ST2_CASE_OPEN] = case_seen;
  end

  // Main registers
  always @(posedge CLK) begin
    if (!RESET_N || restore) begin
      control_q      <= `HWM_RST_CONTROL;
      status1_q      <= `HWM_RST_STATUS;
      status2_q      <= `HWM_RST_STATUS;
      mask1_q        <= `HWM_RST_MASK;
      mask2_q        <= `HWM_RST_MASK;
      case_clr_rsv_q <= 7'h00;
      case_clr_req_q <= 1'b0;
    end else begin
      control_q      <= control_d;
      case_clr_req_q <= case_clr_req_d;
      status1_q <= status_next(status1_q, st1_set, rd_st1,
                               `HWM_ST1_IMPL);
      status2_q <= status_next(status2_q, st2_set, rd_st2,
                               `HWM_ST2_IMPL);
      if (wr_mask1) begin
        mask1_q <= REG_WDATA;
      end
      if (wr_mask2) begin
        mask2_q <= REG_WDATA;
      end
      if (wr_cclr) begin
        case_clr_rsv_q <= REG_WDATA[6:0];
      end
    end
  end

  // Masks gate only the alarm path
  assign st1_alarm = status1_q & ~mask1_q;
  assign st2_alarm = status2_q & (~mask2_q | ~`HWM_MASK2_ALARM)
                     & `HWM_ST2_IMPL;
  assign alarm_any = (|st1_alarm) || (|st2_alarm);

  // Enable and suspend qualify the alarm
  assign alarm_cond = alarm_any && control_q[`HWM_CTL_INT_EN]
                      && !control_q[`HWM_CTL_SUSPEND];

  // Outputs, run bit plays no part in the alarm
  always @(posedge CLK) begin
    if (!RESET_N) begin
      ALARM_INT_N      <= 1'b1;
      MONITOR_RUN      <= 1'b0;
      DEFAULTS_RESTORE <= 1'b0;
    end else begin
      ALARM_INT_N      <= !alarm_cond;
      MONITOR_RUN      <= running && !restore;
      DEFAULTS_RESTORE <= restore;
    end
  end

  // Read data mux
  always @* begin
    case (REG_ADDR)
      `HWM_ADDR_CONTROL: begin
        rdata_d = control_q;
        rdata_d[`HWM_CTL_CASE_CLR] = case_clr_req_q;
      end
      `HWM_ADDR_STATUS1: begin
        rdata_d = status1_q;
      end
      `HWM_ADDR_STATUS2: begin
        rdata_d = status2_q;
      end
      `HWM_ADDR_MASK1: begin
        rdata_d = mask1_q;
      end
      `HWM_ADDR_MASK2: begin
        rdata_d = mask2_q;
      end
      `HWM_ADDR_CASE_CLR: begin
        rdata_d = {case_clr_req_q, case_clr_rsv_q};
      end
      default: begin
        rdata_d = 8'h00;
      end
    endcase
  end

  always @(posedge CLK) begin
    if (!RESET_N) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      REG_RDATA <= rdata_d;
    end
  end

endmodule

// >>> test/hwm_case_model.sv
// Chassis intrusion switch and its open-drain line
`timescale 1ns/10ps
module hwm_case_model (
  input  wire oe,
  input  wire o,
  input  wire opened,
  output wire pin
);
  // Block drive wins; else the switch sets the level
  assign pin = oe ? o : opened;
endmodule

// >>> test/hwm_regs_props.sv
// Port checks for the monitor register bank
`timescale 1ns/10ps
module hwm_regs_props #(
  parameter PULSE_CYCLES = 8
) (
  input wire       CLK,
  input wire       RESET_N,
  input wire [7:0] REG_ADDR,
  input wire       REG_WR,
  input wire [7:0] REG_WDATA,
  input wire       REG_RD,
  input wire [7:0] REG_RDATA,
  input wire       RESET_OUT_N,
  input wire       CASE_OPEN_INPUT_OE,
  input wire       ALARM_INT_N,
  input wire       MONITOR_RUN,
  input wire       DEFAULTS_RESTORE
);
  wire        cw = REG_WR && REG_ADDR == 8'h40;
  reg  [31:0] low_q;
  reg  [31:0] oe_q;
  // Pulse length counters
  always @(posedge CLK) begin
    low_q <= (!RESET_N || RESET_OUT_N) ? 32'h0 : low_q + 32'h1;
    oe_q  <= (!RESET_N || !CASE_OPEN_INPUT_OE) ? 32'h0 : oe_q + 32'h1;
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  rst_state_a: assert property (disable iff (1'b0) !RESET_N |=>
    REG_RDATA == 8'h00 && ALARM_INT_N && !MONITOR_RUN && RESET_OUT_N)
    else $error("state after reset wrong");
  run_start_a: assert property (cw && REG_WDATA[0] && !REG_WDATA[3]
    && !REG_WDATA[7] ##1 !cw |=> MONITOR_RUN) else $error("run not set");
  run_stop_a: assert property (cw && !REG_WDATA[0] ##1 !cw
    |=> !MONITOR_RUN) else $error("run not cleared");
  suspend_a: assert property (cw && REG_WDATA[3] ##1 !cw
    |=> !MONITOR_RUN && ALARM_INT_N) else $error("suspend ignored");
  int_off_a: assert property (cw && !REG_WDATA[1] ##1 !cw
    |=> ALARM_INT_N) else $error("alarm while disabled");
  restore_a: assert property (cw && REG_WDATA[7] ##1 !cw
    |-> DEFAULTS_RESTORE ##1 !DEFAULTS_RESTORE) else $error("restore bad");
  rst_len_a: assert property ($rose(RESET_OUT_N) && !DEFAULTS_RESTORE
    |-> low_q == PULSE_CYCLES) else $error("reset pulse length");
  case_len_a: assert property ($fell(CASE_OPEN_INPUT_OE)
    && !DEFAULTS_RESTORE |-> oe_q == PULSE_CYCLES)
    else $error("intrusion pulse length");
  rdata_hold_a: assert property (!REG_RD |=> $stable(REG_RDATA))
    else $error("read data moved");
endmodule

// >>> test/tb.sv
// Testbench for the monitor register bank
`timescale 1ns/10ps
module tb;
  localparam PC = 8;
  reg        clk = 0, rst_n = 0, wr_s = 0, rd_s = 0, ext = 0, opened = 0;
  reg  [7:0] addr = 8'h00, wdata = 8'h00;
  reg  [9:0] err = 10'h000;
  wire [7:0] rdata;
  wire       alarm_n, run, restore, rst_out_n, oe, case_o, pin;
  integer    err_total = 0, n_compared = 0, i;
  logic [7:0] ex [9] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h40, 8'h80,
                         8'h01, 8'h02};
  hwm_regs #(.PULSE_CYCLES(PC)) DUT (.CLK(clk), .RESET_N(rst_n),
    .REG_ADDR(addr), .REG_WR(wr_s), .REG_WDATA(wdata), .REG_RD(rd_s),
    .REG_RDATA(rdata), .EXTENDED_MODE(ext), .RAIL_2V5_INPUT_ERR(err[0]),
    .CORE_SUPPLY_ONE_ERR(err[1]), .RAIL_3V3_INPUT_ERR(err[2]),
    .RAIL_5V_INPUT_ERR(err[3]), .TEMP_HIGH_ERR(err[4]),
    .TACH_ONE_ERR(err[5]), .TACH_TWO_ERR(err[6]),
    .RAIL_12V_INPUT_ERR(err[7]), .CORE_SUPPLY_TWO_ERR(err[8]),
    .TEMP_BELOW_FLOOR_ERR(err[9]), .CASE_OPEN_INPUT_I(pin),
    .CASE_OPEN_INPUT_O(case_o), .CASE_OPEN_INPUT_OE(oe),
    .RESET_OUT_N(rst_out_n), .ALARM_INT_N(alarm_n), .MONITOR_RUN(run),
    .DEFAULTS_RESTORE(restore));
  hwm_case_model u_case (.oe(oe), .o(case_o), .opened(opened), .pin(pin));
  always #50 clk = ~clk;
  task chk(input string nm, input [7:0] exp, input [7:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(negedge clk); addr = a; wdata = d; wr_s = 1;
    @(negedge clk); wr_s = 0;
  endtask
  task rc(input [7:0] a, input [7:0] exp);
    @(negedge clk); addr = a; rd_s = 1;
    @(negedge clk); rd_s = 0;
    chk("rdata", exp, rdata);
  endtask
  task hit(input integer k);
    @(negedge clk); err[k] = 1;
    @(negedge clk); err[k] = 0;
  endtask
  task give_verdict;
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    give_verdict;
  end
  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1;
    rc(8'h40, 8'h08);
    rc(8'h42, 8'h00);
    wr(8'h41, 8'hff);
    rc(8'h41, 8'h00);
    rc(8'h45, 8'h00);
    hit(5);
    rc(8'h41, 8'h00);
    $display("Test reset and standby done");
    wr(8'h40, 8'h03); // Run and alarm enable set first
    @(negedge clk);
    chk("run", 8'h01, {7'h0, run});
    for (i = 0; i < 9; i++) begin
      hit(i);
      @(negedge clk);
      chk("alarm", 8'h00, {7'h0, alarm_n});
      rc(i < 7 ? 8'h41 : 8'h42, ex[i]);
    end
    hit(9);
    rc(8'h42, 8'h00);
    ext = 1;
    hit(9);
    rc(8'h42, 8'h80);
    opened = 1;
    repeat (6) @(negedge clk);
    opened = 0;
    repeat (4) @(negedge clk);
    rc(8'h42, 8'h10);
    rc(8'h42, 8'h00);
    $display("Test status sources done");
    hit(5);
    wr(8'h40, 8'h02);
    @(negedge clk);
    chk("alarm", 8'h00, {7'h0, alarm_n});
    wr(8'h40, 8'h0a);
    @(negedge clk);
    chk("alarm", 8'h01, {7'h0, alarm_n});
    chk("run", 8'h00, {7'h0, run});
    rc(8'h41, 8'h40);
    wr(8'h40, 8'h03);
    @(negedge clk);
    chk("run", 8'h01, {7'h0, run});
    wr(8'h43, 8'h40);
    hit(5);
    @(negedge clk);
    chk("alarm", 8'h01, {7'h0, alarm_n});
    rc(8'h41, 8'h40);
    wr(8'h43, 8'h00);
    wr(8'h40, 8'h01);
    hit(5);
    @(negedge clk);
    chk("alarm", 8'h01, {7'h0, alarm_n});
    rc(8'h41, 8'h40);
    $display("Test alarm control done");
    wr(8'h40, 8'h11);
    chk("rst_out", 8'h01, {7'h0, rst_out_n});
    wr(8'h44, 8'h80);
    wr(8'h40, 8'h11);
    chk("rst_out", 8'h00, {7'h0, rst_out_n});
    rc(8'h40, 8'h11);
    repeat (5) @(negedge clk);
    chk("rst_out", 8'h00, {7'h0, rst_out_n});
    @(negedge clk);
    chk("rst_out", 8'h01, {7'h0, rst_out_n});
    rc(8'h40, 8'h01);
    opened = 1;
    wr(8'h46, 8'h80);
    chk("pin", 8'h00, {7'h0, pin});
    opened = 0;
    rc(8'h40, 8'h41);
    rc(8'h46, 8'h80);
    repeat (3) @(negedge clk);
    chk("case_oe", 8'h01, {7'h0, oe});
    @(negedge clk);
    chk("case_oe", 8'h00, {7'h0, oe});
    rc(8'h46, 8'h00);
    wr(8'h40, 8'h41);
    rc(8'h46, 8'h80);
    $display("Test pin pulses done");
    wr(8'h43, 8'hff);
    wr(8'h40, 8'h83);
    chk("restore", 8'h01, {7'h0, restore});
    rc(8'h40, 8'h08);
    rc(8'h43, 8'h00);
    rc(8'h46, 8'h00);
    chk("run", 8'h00, {7'h0, run});
    $display("Test restore done");
    give_verdict;
  end
endmodule
bind hwm_regs hwm_regs_props #(.PULSE_CYCLES(PULSE_CYCLES)) u_props (
  .CLK, .RESET_N, .REG_ADDR, .REG_WR, .REG_WDATA, .REG_RD, .REG_RDATA,
  .RESET_OUT_N, .CASE_OPEN_INPUT_OE, .ALARM_INT_N, .MONITOR_RUN,
  .DEFAULTS_RESTORE);
